// *** hdl/cadc_pkg.sv ***
// constants shared by the current converter control and its filter
package cadc_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SETTLE_US = 100;  // current_settle_time
  localparam int SETTLE_CYC = (SETTLE_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int MOD_DIV = 4;      // modulator bit rate divider
  localparam int SKIP_OUTS = 2;    // filter outputs dropped after start

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h01;
  localparam logic [7:0] OFS_PIN_CFG_TWO = 8'h02;
  localparam logic [7:0] OFS_RES_HIGH = 8'h03;
  localparam logic [7:0] OFS_RES_MID = 8'h04;
  localparam logic [7:0] OFS_RES_LOW = 8'h05;
  localparam logic [7:0] OFS_STATUS = 8'h06;
  localparam logic [7:0] OFS_MASK = 8'h07;
  localparam logic [7:0] OFS_RUN_STAT = 8'h08;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int CTL1_GO = 0;      // write one starts or stops
  localparam int CTL1_MODE_LO = 1; // two bits
  localparam int CTL1_DEC_LO = 3;  // two bits, current_decimation_sel
  localparam int CTL2_ALIGN = 0;   // aux cell align selector
  localparam int CTL2_TGT_LO = 1;  // five bits, target main slot
  localparam int PIN2_RDY_EN = 0;
  localparam int ST_DONE = 0;
  localparam int ST_OVR = 1;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] CTL2_RST = 8'h00;
  localparam logic [7:0] PIN2_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;

  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic ALIGN_DYN = 1'h0;
  localparam logic ALIGN_FIXED = 1'h1;

  // ------------------------------------------------------------
  // aux slot layout
  // ------------------------------------------------------------
  localparam logic [4:0] AUX_BAL_CODE = 5'h05;     // balance-channel item
  localparam logic [4:0] MAIN_SLOT_CELL8 = 5'h0C;  // main slot of cell 8
  localparam logic [4:0] AUX_SLOTS = 5'h10;        // aux slots per round

  // ------------------------------------------------------------
  // result coding, 24-bit two's complement
  // ------------------------------------------------------------
  localparam logic signed [24:0] FS_POS = 25'sh07F_FFF0;  // overrange edge
  localparam logic signed [24:0] FS_NEG = -25'sh07F_FFF0;
  localparam logic [23:0] SAT_POS = 24'h4C_CCCC;  // about 75 mV reading
  localparam logic [23:0] SAT_NEG = 24'hB3_3334;

  typedef enum logic [1:0] {CADC_IDLE, CADC_SETTLE, CADC_RUN} cadc_state_t;
endpackage : cadc_pkg

// *** hdl/cadc_sinc3.sv ***
// third-order sinc decimator for the current modulator bit stream
module cadc_sinc3
  import cadc_pkg::*;
(
  input wire logic i_mclk,                 // system clock
  input wire logic i_rst_n,                // async reset, active low
  input wire logic i_clear,                // restart filter
  input wire logic i_mod_en,               // modulator bit strobe
  input wire logic i_mod_bit,              // modulator output bit
  input wire logic [1:0] i_dec_sel,        // decimation selector
  output logic o_valid,                    // result pulse
  output logic signed [24:0] o_raw         // signed result, full scale 2^23
);
  logic [24:0] int1_q, int2_q, int3_q;
  logic [24:0] dly1_q, dly2_q, dly3_q;
  logic [7:0] dec_cnt_q;
  logic [1:0] skip_q;
  logic [24:0] c1, c2, c3;
  logic [24:0] int1_d, int2_d, int3_d;
  logic [7:0] dec_last;
  logic [4:0] shift;

  // ratio 32/64/128/256 and the gain shift to reach 2^24
  assign dec_last = 8'(({8'h00, 8'h20} << i_dec_sel) - 16'h0001);
  assign shift = 5'(5'h09 - 5'(3 * i_dec_sel));
  // integrator sums that include this bit, so the third output is fully settled
  assign int1_d = int1_q + {24'h00_0000, i_mod_bit};
  assign int2_d = int2_q + int1_d;
  assign int3_d = int3_q + int2_d;
  assign c1 = int3_d - dly1_q;
  assign c2 = c1 - dly2_q;
  assign c3 = c2 - dly3_q;

  // integrators at the modulator bit rate, comb stages at the decimated rate
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int1_q <= '0;
      int2_q <= '0;
      int3_q <= '0;
      dly1_q <= '0;
      dly2_q <= '0;
      dly3_q <= '0;
      dec_cnt_q <= '0;
    end else if (i_clear) begin
      int1_q <= '0;
      int2_q <= '0;
      int3_q <= '0;
      dly1_q <= '0;
      dly2_q <= '0;
      dly3_q <= '0;
      dec_cnt_q <= '0;
    end else if (i_mod_en) begin
      int1_q <= int1_d;
      int2_q <= int2_d;
      int3_q <= int3_d;
      dec_cnt_q <= (dec_cnt_q == dec_last) ? 8'h00 : dec_cnt_q + 8'h01;
      if (dec_cnt_q == dec_last) begin
        dly1_q <= int3_d;
        dly2_q <= c1;
        dly3_q <= c2;
      end
    end
  end

  // first two outputs only fill the pipe; third is the first result
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      skip_q <= '0;
      o_valid <= 1'b0;
      o_raw <= '0;
    end else begin
      o_valid <= 1'b0;
      if (i_clear) begin
        skip_q <= '0;
      end else if (i_mod_en && dec_cnt_q == dec_last) begin
        if (skip_q == 2'(SKIP_OUTS)) begin
          o_valid <= 1'b1;
          o_raw <= $signed((c3 << shift) - 25'h080_0000);
        end else begin
          skip_q <= skip_q + 2'h1;
        end
      end
    end
  end
endmodule : cadc_sinc3

// *** hdl/cadc_ctrl.sv ***
// current converter control, result registers and aux slot alignment
// Behaviour
// R01: align selector zero moves balance slot to target
// R02: die temp slot first, other aux slots shift
// R03: align selector one pins balance to slot 12
// R04: differential input, plus/minus 125 mV full scale
// R05: overrange result saturates near 75 mV
// R06: two-bit selector sets decimation ratio
// R07: shared start and mode, both converters stop together
// R08: result is 24-bit two's complement, three bytes
// R09: settle, first result full period, then third
// R10: ready pin low on completion, high on read
// R11: host sets ready enable bit to use pin
// R12: three result bytes read as one conversion
//
// Design decisions made here: the register offsets and strobed register access.
module cadc_ctrl
  import cadc_pkg::*;
(
  input wire logic i_mclk,           // 10 MHz clock
  input wire logic i_rst_n,          // async reset, active low
  input wire logic [7:0] i_addr,     // register address
  input wire logic [7:0] i_wdata,    // write data
  input wire logic i_wr,             // write strobe
  input wire logic i_rd,             // read strobe
  output logic [7:0] o_rdata,        // read data, cycle after strobe
  input wire logic i_mod_bit,        // sense_pos_pin minus sense_neg_pin bit
  output logic o_mod_en,             // modulator bit strobe
  output logic o_conv_run,           // shared run level, both converters
  input wire logic [4:0] i_main_slot, // current main converter slot
  input wire logic i_main_round,     // pulse, main round starts
  output logic [4:0] o_aux_item,     // aux measurement for this slot
  output logic o_aux_bal,            // aux slot is the balance channel
  input wire logic i_gpio1,          // first gpio pin level
  output logic o_gpio1,              // first gpio pin drive value
  output logic o_gpio1_oe_n,         // low while driving the pin
  output logic o_irq                 // level interrupt
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  cadc_state_t state_q, state_d;
  logic [7:0] ctl1_q, ctl2_q, pin2_q, mask_q, status_q;
  logic [1:0] mode_q;         // mode latched at go
  logic [1:0] dec_q;          // ratio latched at go
  logic [23:0] result_q;      // last conversion, all bytes together
  logic [15:0] shadow_q;      // mid and low frozen at high read
  logic rdy_n_q;              // ready pin level
  logic [9:0] settle_q;
  logic [1:0] div_q;
  logic [4:0] aux_pos_q;
  logic [7:0] rdata_q;
  logic go, go_start, go_stop, rd_high;
  logic flt_valid, flt_clear, ovr;
  logic signed [24:0] flt_raw;
  logic [23:0] clamped;
  logic [4:0] bal_pos;
  logic [7:0] status_set;

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  // register hit check used by decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  // aux item for a slot position, skipping the balance position
  function automatic logic [4:0] aux_item_of(input logic [4:0] pos,
                                             input logic [4:0] bal);
    logic [4:0] idx;
    idx = (pos < bal) ? pos : pos - 5'h01;
    if (pos == bal) begin
      return AUX_BAL_CODE;
    end
    return (idx < AUX_BAL_CODE) ? idx : idx + 5'h01;
  endfunction : aux_item_of

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  assign go = i_wr && hit(i_addr, OFS_CTRL_ONE) && i_wdata[CTL1_GO];
  assign go_start = go && (i_wdata[CTL1_MODE_LO +: 2] != MODE_STOP);  // R07
  assign go_stop = go && (i_wdata[CTL1_MODE_LO +: 2] == MODE_STOP);   // R07
  assign rd_high = i_rd && hit(i_addr, OFS_RES_HIGH);

  // control registers, go bit is not stored
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl1_q <= CTL1_RST;
      ctl2_q <= CTL2_RST;
      pin2_q <= PIN2_RST;
      mask_q <= MASK_RST;
    end else if (i_wr) begin
      if (hit(i_addr, OFS_CTRL_ONE)) begin
        ctl1_q <= {3'h0, i_wdata[4:1], 1'b0};
      end
      if (hit(i_addr, OFS_CTRL_TWO)) begin
        ctl2_q <= {2'h0, i_wdata[5:0]};
      end
      if (hit(i_addr, OFS_PIN_CFG_TWO)) begin
        pin2_q <= {7'h00, i_wdata[PIN2_RDY_EN]};  // R11
      end
      if (hit(i_addr, OFS_MASK)) begin
        mask_q <= {6'h00, i_wdata[1:0]};
      end
    end
  end

  // ------------------------------------------------------------
  // run sequencing
  // ------------------------------------------------------------
  // settle after go, then run until single result or stop command
  always_comb begin
    state_d = state_q;
    case (state_q)
      CADC_IDLE: begin
        if (go_start) begin
          state_d = CADC_SETTLE;  // R09
        end
      end
      CADC_SETTLE: begin
        if (go_stop) begin
          state_d = CADC_IDLE;
        end else if (settle_q == 10'(SETTLE_CYC - 1)) begin
          state_d = CADC_RUN;     // R09
        end
      end
      CADC_RUN: begin
        if (go_stop) begin
          state_d = CADC_IDLE;    // R07
        end else if (go_start) begin
          state_d = CADC_SETTLE;
        end else if (flt_valid && mode_q == MODE_SINGLE) begin
          state_d = CADC_IDLE;
        end
      end
      default: begin
        state_d = CADC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= CADC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // settings sampled at go
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= MODE_STOP;
      dec_q <= 2'h0;
    end else if (go_start) begin
      mode_q <= i_wdata[CTL1_MODE_LO +: 2];
      dec_q <= i_wdata[CTL1_DEC_LO +: 2];  // R06
    end
  end

  // settling counter
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settle_q <= '0;
    end else if (state_q != CADC_SETTLE || go_start) begin
      settle_q <= '0;
    end else begin
      settle_q <= settle_q + 10'h001;
    end
  end

  // modulator bit rate enable
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= '0;
    end else if (state_q != CADC_RUN) begin
      div_q <= '0;
    end else begin
      div_q <= (div_q == 2'(MOD_DIV - 1)) ? 2'h0 : div_q + 2'h1;
    end
  end

  assign o_mod_en = (state_q == CADC_RUN) && (div_q == 2'(MOD_DIV - 1));
  assign o_conv_run = (state_q != CADC_IDLE);  // R07
  assign flt_clear = (state_q != CADC_RUN);

  // ------------------------------------------------------------
  // filter and result coding
  // ------------------------------------------------------------
  cadc_sinc3 u_sinc3 (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_clear(flt_clear),
    .i_mod_en(o_mod_en),
    .i_mod_bit(i_mod_bit),
    .i_dec_sel(dec_q),
    .o_valid(flt_valid),
    .o_raw(flt_raw)
  );

  // full scale maps to plus/minus 2^23, beyond it clamp near 75 mV
  assign ovr = (flt_raw >= FS_POS) || (flt_raw <= FS_NEG);  // R04
  assign clamped = !ovr ? flt_raw[23:0] :
                   (flt_raw[24] ? SAT_NEG : SAT_POS);       // R05

  // all three bytes updated in one edge
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result_q <= '0;
    end else if (flt_valid && state_q == CADC_RUN) begin
      result_q <= clamped;  // R08 R12
    end
  end

  // mid and low frozen when the high byte is read
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shadow_q <= '0;
    end else if (rd_high) begin
      shadow_q <= result_q[15:0];  // R12
    end
  end

  // ------------------------------------------------------------
  // ready pin and interrupt
  // ------------------------------------------------------------
  // completion pulls low, high byte read releases, completion wins
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdy_n_q <= 1'b1;
    end else if (flt_valid && state_q == CADC_RUN) begin
      rdy_n_q <= 1'b0;  // R10
    end else if (rd_high) begin
      rdy_n_q <= 1'b1;  // R10
    end
  end

  assign o_gpio1 = rdy_n_q;
  assign o_gpio1_oe_n = !pin2_q[PIN2_RDY_EN];  // R10 R11

  assign status_set = {6'h00, ovr && flt_valid && state_q == CADC_RUN,
                       flt_valid && state_q == CADC_RUN};

  // sticky status, write one clears, new event wins
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_q <= '0;
    end else if (i_wr && hit(i_addr, OFS_STATUS)) begin
      status_q <= (status_q & ~i_wdata) | status_set;
    end else begin
      status_q <= status_q | status_set;
    end
  end

  assign o_irq = |(status_q & mask_q);

  // ------------------------------------------------------------
  // aux slot alignment
  // ------------------------------------------------------------
  // balance slot follows target main slot or fixed cell 8 slot
  assign bal_pos = (ctl2_q[CTL2_ALIGN] == ALIGN_DYN) ?
                   ctl2_q[CTL2_TGT_LO +: 5] :  // R01
                   MAIN_SLOT_CELL8;            // R03

  // aux slot position runs with the main slot stream
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aux_pos_q <= '0;
    end else if (i_main_round) begin
      aux_pos_q <= '0;  // R02
    end else if (o_conv_run) begin
      aux_pos_q <= i_main_slot;
    end
  end

  // position zero is die_temp_sensor_two, the rest shift around
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_aux_item <= '0;
      o_aux_bal <= 1'b0;
    end else begin
      o_aux_item <= aux_item_of(aux_pos_q, bal_pos);  // R01 R02 R03
      o_aux_bal <= (aux_pos_q == bal_pos) && (aux_pos_q < AUX_SLOTS);
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= '0;
    end else if (i_rd) begin
      case (i_addr)
        OFS_CTRL_ONE: rdata_q <= ctl1_q;
        OFS_CTRL_TWO: rdata_q <= ctl2_q;
        OFS_PIN_CFG_TWO: rdata_q <= pin2_q;
        OFS_RES_HIGH: rdata_q <= result_q[23:16];  // R08
        OFS_RES_MID: rdata_q <= shadow_q[15:8];
        OFS_RES_LOW: rdata_q <= shadow_q[7:0];
        OFS_STATUS: rdata_q <= status_q;
        OFS_MASK: rdata_q <= mask_q;
        OFS_RUN_STAT: rdata_q <= {4'h0, i_gpio1, !rdy_n_q, state_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata = rdata_q;
endmodule : cadc_ctrl

// *** verification/cadc_ctrl_checker.sv ***
// port assertions for the current converter control
module cadc_ctrl_checker
  import cadc_pkg::*;
(
  input wire logic i_mclk, // clock
  input wire logic i_rst_n, // reset, active low
  input wire logic [7:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic [7:0] o_rdata, // read data
  input wire logic o_mod_en, // modulator strobe
  input wire logic o_conv_run, // shared run level
  input wire logic [4:0] i_main_slot, // main slot
  input wire logic [4:0] o_aux_item, // aux item code
  input wire logic o_aux_bal, // balance slot flag
  input wire logic o_gpio1, // ready level
  input wire logic o_gpio1_oe_n // pin drive enable, low drives
);
  timeunit 1ns;
  timeprecision 1ns;

  logic align_q;
  logic [4:0] tgt_q;
  logic rdy_en_q;
  logic [4:0] bpos;
  logic go_w;

  // ------------------------------------------------------------
  // shadow of alignment and pin settings
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      align_q <= 1'b0;
      tgt_q <= 5'h00;
      rdy_en_q <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == OFS_CTRL_TWO) begin
        align_q <= i_wdata[CTL2_ALIGN];
        tgt_q <= i_wdata[CTL2_TGT_LO +: 5];
      end
      if (i_addr == OFS_PIN_CFG_TWO) begin
        rdy_en_q <= i_wdata[PIN2_RDY_EN];
      end
    end
  end

  // expected balance position and go strobe
  assign bpos = (align_q == ALIGN_FIXED) ? MAIN_SLOT_CELL8 : tgt_q;
  assign go_w = i_wr && (i_addr == OFS_CTRL_ONE) && i_wdata[CTL1_GO];

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  ready_release_a: assert property ($rose(o_gpio1) |-> $past(i_rd) && $past(i_addr) == OFS_RES_HIGH)
    else $error("ready released without high byte read");
  ready_cause_a: assert property ($fell(o_gpio1) |-> $past(o_conv_run))
    else $error("ready without running conversion");
  mod_gap_a: assert property (o_mod_en |=> !o_mod_en [*3])
    else $error("modulator strobe too close");
  mod_in_run_a: assert property (o_mod_en |-> o_conv_run)
    else $error("modulator strobe while stopped");
  go_start_a: assert property (go_w && i_wdata[CTL1_MODE_LO +: 2] != MODE_STOP
    |=> (o_conv_run && !o_mod_en) [*8])
    else $error("start did not enter settle");
  go_stop_a: assert property (go_w && i_wdata[CTL1_MODE_LO +: 2] == MODE_STOP
    |=> !o_conv_run && !o_mod_en)
    else $error("stop did not halt both converters");
  bal_slot_a: assert property ($past(o_conv_run, 2) && o_conv_run
    |-> o_aux_bal == ($past(i_main_slot, 2) == bpos))
    else $error("balance slot misplaced");
  bal_code_a: assert property (o_aux_bal |-> o_aux_item == AUX_BAL_CODE)
    else $error("balance slot item wrong");
  die_first_a: assert property ($past(o_conv_run, 2) && o_conv_run
    && $past(i_main_slot, 2) == 5'h00 && bpos != 5'h00 |-> o_aux_item == 5'h00)
    else $error("die temperature not first");
  pin_drive_a: assert property (o_gpio1_oe_n == !rdy_en_q)
    else $error("pin drive enable wrong");
endmodule : cadc_ctrl_checker

bind cadc_ctrl cadc_ctrl_checker u_chk (.i_mclk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .o_mod_en, .o_conv_run, .i_main_slot, .o_aux_item, .o_aux_bal, .o_gpio1,
  .o_gpio1_oe_n);

// *** verification/cadc_far_model.sv ***
// modulator bit source and main slot sequencer beside the converter
module cadc_far_model
  import cadc_pkg::*;
(
  input wire logic i_mclk, // clock
  input wire logic i_rst_n, // reset, active low
  input wire logic i_conv_run, // shared run level
  input wire logic [1:0] i_level, // 0 low, 1 high, 2 mid scale
  output logic o_mod_bit, // modulator bit
  output logic [4:0] o_main_slot, // main slot number
  output logic o_main_round // round start pulse
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] hold_q;

  // differential bit stream, toggles while stopped
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mod_bit <= 1'b0;
    end else if (!i_conv_run) begin
      o_mod_bit <= !o_mod_bit;
    end else if (i_level == 2'h2) begin
      // one flip per four clocks, so each strobe sees the opposite bit
      o_mod_bit <= (hold_q[1:0] == 2'h0) ? !o_mod_bit : o_mod_bit;
    end else begin
      o_mod_bit <= i_level[0];
    end
  end

  // main slots advance only on the shared run level
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_q <= 3'h0;
      o_main_slot <= 5'h00;
      o_main_round <= 1'b0;
    end else if (!i_conv_run) begin
      hold_q <= 3'h0;
      o_main_slot <= 5'h00;
      o_main_round <= 1'b0;
    end else begin
      hold_q <= hold_q + 3'h1;
      o_main_round <= (hold_q == 3'h7) && (o_main_slot == AUX_SLOTS - 5'h01);
      if (hold_q == 3'h7) begin
        o_main_slot <= (o_main_slot == AUX_SLOTS - 5'h01) ? 5'h00 : o_main_slot + 5'h01;
      end
    end
  end
endmodule : cadc_far_model

// *** verification/tb.sv ***
// self-checking bench for the current converter control
module tb
  import cadc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [1:0] level = 2'h1;
  logic [7:0] rdata;
  logic mod_bit, mod_en, conv_run, main_round, aux_bal, gpio1, gpio1_oe_n, irq;
  logic [4:0] main_slot, aux_item;
  logic pin_lvl;
  int failures = 0;
  int compares = 0;
  int cyc = 0;

  // ------------------------------------------------------------
  // clock, pin with pull-up, cycle stamp
  // ------------------------------------------------------------
  always #50 i_mclk = ~i_mclk;
  assign pin_lvl = gpio1_oe_n ? 1'b1 : gpio1;
  always @(posedge i_mclk) cyc++;

  cadc_ctrl DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_mod_bit(mod_bit), .o_mod_en(mod_en),
    .o_conv_run(conv_run), .i_main_slot(main_slot), .i_main_round(main_round),
    .o_aux_item(aux_item), .o_aux_bal(aux_bal), .i_gpio1(pin_lvl), .o_gpio1(gpio1),
    .o_gpio1_oe_n(gpio1_oe_n), .o_irq(irq));
  cadc_far_model u_far (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_conv_run(conv_run),
    .i_level(level), .o_mod_bit(mod_bit), .o_main_slot(main_slot),
    .o_main_round(main_round));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // waits for the ready level to drop, returns the cycle stamp
  task automatic wait_fall(output int t);
    int n;
    n = 0;
    while (gpio1 !== 1'b0 && n < 8000) begin
      @(posedge i_mclk);
      #1 n++;
    end
    t = cyc;
  endtask : wait_fall

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] d;
    chk("ready idle", 24'(gpio1), 24'h1);
    chk("pin released", 24'(gpio1_oe_n), 24'h1);
    chk("irq idle", 24'(irq), 24'h0);
    rd(OFS_CTRL_TWO, d);
    chk("ctrl two reset", 24'(d), 24'(CTL2_RST));
    rd(OFS_PIN_CFG_TWO, d);
    chk("pin cfg reset", 24'(d), 24'(PIN2_RST));
    rd(8'h3F, d);
    chk("unmapped read", 24'(d), 24'h0);
    rd(OFS_RUN_STAT, d);
    chk("run status idle", 24'(d), 24'h08);
  endtask : t_reset

  // single conversion, read as three bytes
  task automatic t_sat(input logic [1:0] lvl, input logic [7:0] c2, input logic [23:0] exp);
    logic [7:0] h, m, l;
    int t;
    @(posedge i_mclk);
    level <= lvl;
    wr(OFS_PIN_CFG_TWO, 8'h01);
    wr(OFS_CTRL_TWO, c2);
    wr(OFS_MASK, 8'h01);
    wr(OFS_CTRL_ONE, 8'h03);
    wait_fall(t);
    chk("ready pin low", 24'(pin_lvl), 24'h0);
    repeat (2) @(posedge i_mclk);
    #1 chk("single stops", 24'(conv_run), 24'h0);
    chk("irq on done", 24'(irq), 24'h1);
    rd(OFS_RUN_STAT, h);
    chk("run status ready", 24'(h), 24'h04);
    rd(OFS_RES_HIGH, h);
    rd(OFS_RES_MID, m);
    rd(OFS_RES_LOW, l);
    chk("result", {h, m, l}, exp);
    chk("ready released", 24'(gpio1), 24'h1);
    wr(OFS_MASK, 8'h00);
    #1 chk("irq masked", 24'(irq), 24'h0);
    wr(OFS_STATUS, 8'h03);
    rd(OFS_STATUS, h);
    chk("status cleared", 24'(h), 24'h0);
  endtask : t_sat

  // continuous run: settle, first and later conversion times
  task automatic t_rate(input logic [1:0] sel);
    int t0, t1, t2, base;
    logic [7:0] d;
    base = SETTLE_CYC + 3 * (32 << sel) * MOD_DIV;
    @(posedge i_mclk);
    level <= 2'h2;
    wr(OFS_CTRL_ONE, {3'h0, sel, MODE_CONT, 1'b1});
    #1 t0 = cyc;
    wait_fall(t1);
    chk("first delay ok", 24'(t1 - t0 >= base && t1 - t0 <= base + 8), 24'h1);
    rd(OFS_RES_HIGH, d);
    wait_fall(t2);
    chk("later period", 24'(t2 - t1), 24'((32 << sel) * MOD_DIV));
    wr(OFS_CTRL_ONE, 8'h01);
    #1 chk("stopped", 24'(conv_run), 24'h0);
    rd(OFS_RES_HIGH, d);
  endtask : t_rate

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    #1 t_reset();
    t_sat(2'h1, 8'h01, SAT_POS);
    t_sat(2'h0, 8'h06, SAT_NEG);
    t_sat(2'h2, 8'h00, 24'h00_0000);
    for (int s = 0; s < 4; s++) begin
      t_rate(s[1:0]);
    end
    conclude();
  end

  initial begin
    repeat (40000) @(posedge i_mclk);
    failures++;
    $display("[ERR] run time expected end seen timeout");
    conclude();
  end
endmodule : tb
